// ===== logic/ests_trigger_sync.sv
// Chosen here: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
module ests_trigger_sync
	import ests_pkg::*;
#(
	parameter int CNT_W   = 32,
	parameter int LATENCY = CONV_CYC
) (
	input  wire logic             clk,
	input  wire logic             nrst,
	input  wire logic             ce,
	input  wire logic [CNT_W-1:0] counterIn,
	input  wire logic             sync0Pulse,
	input  wire logic             sync1Pulse,
	input  wire logic             frameExchange,
	input  wire logic             frameRead,
	output logic [CNT_W-1:0]      pdPosition,
	output logic                  pdFresh,
	output logic                  sampleTrig,
	input  wire logic [7:0]       s_axi_awaddr,
	input  wire logic             s_axi_awvalid,
	output logic                  s_axi_awready,
	input  wire logic [31:0]      s_axi_wdata,
	input  wire logic [3:0]       s_axi_wstrb,
	input  wire logic             s_axi_wvalid,
	output logic                  s_axi_wready,
	output logic [1:0]            s_axi_bresp,
	output logic                  s_axi_bvalid,
	input  wire logic             s_axi_bready,
	input  wire logic [7:0]       s_axi_araddr,
	input  wire logic             s_axi_arvalid,
	output logic                  s_axi_arready,
	output logic [31:0]           s_axi_rdata,
	output logic [1:0]            s_axi_rresp,
	output logic                  s_axi_rvalid,
	input  wire logic             s_axi_rready
);
	initial begin
		if (CNT_W < 1 || CNT_W > 32 || LATENCY < 1)
			$error("bad trigger parameters");
	end

	logic [7:0]  mode_q;
	logic        syncEn_q;
	logic        run_q;
	logic [31:0] period_q;
	logic [31:0] shift_q;
	logic [31:0] minCyc_q;
	logic [15:0] missed_q;
	logic        measReq_q;
	logic        measOn_q;
	logic [31:0] measCnt_q;
	logic [31:0] inShift_q;
	logic [CNT_W-1:0] pos_q;
	logic        fresh_q;
	logic        pending_q;
	logic [CNT_W-1:0] hold_q;
	logic [31:0] phase_q;
	logic        armed_q;
	logic [31:0] dly_q;

	logic        dcMode;
	logic        trig;
	logic        busy;
	logic        done;
	logic [CNT_W-1:0] sample;

	// axi handshake state
	logic [7:0]  awAddr_q;
	logic        awHave_q;
	logic [31:0] wData_q;
	logic [3:0]  wStrb_q;
	logic        wHave_q;
	logic        bValid_q;
	logic [1:0]  bResp_q;
	logic        rValid_q;
	logic [31:0] rData_q;
	logic [1:0]  rResp_q;
	logic        wrFire;

	assign dcMode = (mode_q == MODE_SYNC0) && syncEn_q;

	// sync0 starts a delayed local event; sync1 never used
	always_ff @(posedge clk) begin
		if (!nrst) begin
			dly_q   <= 32'h0;
			armed_q <= 1'b0;
			phase_q <= 32'h0;
		end else if (ce) begin
			if (dcMode && sync0Pulse) begin
				armed_q <= 1'b1;
				dly_q   <= shift_q[31] ? 32'h0 : shift_q / 32'(CLK_NS);
			end else if (armed_q) begin
				if (dly_q == 32'h0)
					armed_q <= 1'b0;
				else
					dly_q <= dly_q - 32'h1;
			end
			if (trig)
				phase_q <= 32'h0;
			else if (phase_q != 32'hFFFFFFFF)
				phase_q <= phase_q + 32'h1;
		end
	end

	// one trigger per sync0 period; negative shift acts one cycle after pulse
	assign trig = dcMode ? (armed_q && dly_q == 32'h0)
		: (mode_q == MODE_FRAME && frameExchange);
	assign sampleTrig = trig;

	ests_sampler #(
		.WIDTH  (CNT_W),
		.LATENCY(LATENCY)
	) u_sampler (
		.clk   (clk),
		.nrst  (nrst),
		.ce    (ce),
		.trig  (trig),
		.cntIn (counterIn),
		.busy  (busy),
		.done  (done),
		.sample(sample)
	);

	// process-data buffer: whole word copied at once
	always_ff @(posedge clk) begin
		if (!nrst) begin
			hold_q    <= '0;
			pending_q <= 1'b0;
			pos_q     <= '0;
			fresh_q   <= 1'b0;
			missed_q  <= 16'h0;
		end else if (ce) begin
			if (done) begin
				hold_q    <= sample;
				pending_q <= 1'b1;
			end
			if (frameRead) begin
				if (pending_q) begin
					pos_q     <= hold_q;
					fresh_q   <= 1'b1;
					pending_q <= done;
				end else begin
					fresh_q  <= 1'b0;
					missed_q <= missed_q + 16'h1;
				end
			end
		end
	end

	assign pdPosition = pos_q;
	assign pdFresh    = fresh_q;

	// processing time measurement and input shift report
	always_ff @(posedge clk) begin
		if (!nrst) begin
			measOn_q  <= 1'b0;
			measCnt_q <= 32'h0;
			minCyc_q  <= 32'h0;
			inShift_q <= 32'h0;
		end else if (ce) begin
			if (measReq_q && trig) begin
				measOn_q  <= 1'b1;
				measCnt_q <= 32'h0;
			end else if (measOn_q) begin
				measCnt_q <= measCnt_q + 32'(CLK_NS);
				if (done) begin
					measOn_q <= 1'b0;
					minCyc_q <= measCnt_q + 32'(CLK_NS);
				end
			end
			if (dcMode && sync0Pulse)
				inShift_q <= shift_q[31] ? 32'h0 : shift_q;
		end
	end

	// axi4-lite write path
	assign s_axi_awready = !awHave_q && !bValid_q;
	assign s_axi_wready  = !wHave_q && !bValid_q;
	assign wrFire        = awHave_q && wHave_q && !bValid_q;

	always_ff @(posedge clk) begin
		if (!nrst) begin
			awHave_q <= 1'b0;
			awAddr_q <= 8'h0;
			wHave_q  <= 1'b0;
			wData_q  <= 32'h0;
			wStrb_q  <= 4'h0;
			bValid_q <= 1'b0;
			bResp_q  <= RESP_OKAY;
		end else if (ce) begin
			if (s_axi_awvalid && s_axi_awready) begin
				awHave_q <= 1'b1;
				awAddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wHave_q <= 1'b1;
				wData_q <= s_axi_wdata;
				wStrb_q <= s_axi_wstrb;
			end
			if (wrFire) begin
				awHave_q <= 1'b0;
				wHave_q  <= 1'b0;
				bValid_q <= 1'b1;
				unique case (awAddr_q)
					ADDR_CTRL, ADDR_PERIOD, ADDR_SHIFT: bResp_q <= RESP_OKAY;
					default:                            bResp_q <= RESP_SLVERR;
				endcase
			end else if (bValid_q && s_axi_bready) begin
				bValid_q <= 1'b0;
			end
		end
	end

	// control registers
	always_ff @(posedge clk) begin
		if (!nrst) begin
			mode_q    <= MODE_RST;
			syncEn_q  <= 1'b0;
			run_q     <= 1'b0;
			period_q  <= PERIOD_RST;
			shift_q   <= 32'h0;
			measReq_q <= 1'b0;
		end else if (ce) begin
			if (measReq_q && trig)
				measReq_q <= 1'b0;
			if (wrFire && awAddr_q == ADDR_CTRL) begin
				if (wStrb_q[0] && !run_q)
					mode_q <= wData_q[CTRL_MODE_LSB +: 8];
				if (wStrb_q[1]) begin
					syncEn_q <= wData_q[CTRL_EN_BIT];
					run_q    <= wData_q[CTRL_RUN_BIT];
					if (wData_q[CTRL_MEAS_BIT])
						measReq_q <= 1'b1;
				end
			end
			if (wrFire && awAddr_q == ADDR_PERIOD && !run_q) begin
				for (int i = 0; i < 4; i++) begin
					if (wStrb_q[i])
						period_q[i*8 +: 8] <= wData_q[i*8 +: 8];
				end
			end
			if (wrFire && awAddr_q == ADDR_SHIFT && !run_q) begin
				for (int i = 0; i < 4; i++) begin
					if (wStrb_q[i])
						shift_q[i*8 +: 8] <= wData_q[i*8 +: 8];
				end
			end
		end
	end

	assign s_axi_bvalid = bValid_q;
	assign s_axi_bresp  = bResp_q;

	// axi4-lite read path
	assign s_axi_arready = !rValid_q;

	always_ff @(posedge clk) begin
		if (!nrst) begin
			rValid_q <= 1'b0;
			rData_q  <= 32'h0;
			rResp_q  <= RESP_OKAY;
		end else if (ce) begin
			if (s_axi_arvalid && s_axi_arready) begin
				rValid_q <= 1'b1;
				rResp_q  <= RESP_OKAY;
				unique case (s_axi_araddr)
					ADDR_CTRL: rData_q <= {21'h0, measReq_q, run_q,
						syncEn_q, mode_q};
					ADDR_PERIOD:   rData_q <= period_q;
					ADDR_SHIFT:    rData_q <= shift_q;
					ADDR_STATUS:   rData_q <= {29'h0, fresh_q, pending_q,
						busy};
					ADDR_POS:      rData_q <= 32'(pos_q);
					ADDR_INSHIFT:  rData_q <= inShift_q;
					ADDR_MINCYC:   rData_q <= minCyc_q;
					ADDR_MISSED:   rData_q <= {16'h0, missed_q};
					default: begin
						rData_q <= 32'h0;
						rResp_q <= RESP_SLVERR;
					end
				endcase
			end else if (rValid_q && s_axi_rready) begin
				rValid_q <= 1'b0;
			end
		end
	end

	assign s_axi_rvalid = rValid_q;
	assign s_axi_rdata  = rData_q;
	assign s_axi_rresp  = rResp_q;

	// assertions
	sequence sFrameTrig;
		ce && !dcMode && mode_q == MODE_FRAME && frameExchange;
	endsequence

	chk_frame_trigger: assert property (@(posedge clk) disable iff (!nrst)
		sFrameTrig |-> sampleTrig)
		else $error("frame exchange did not trigger sample");

	chk_sync1_ignored: assert property (@(posedge clk) disable iff (!nrst)
		(sync1Pulse && !sync0Pulse && !armed_q && !frameExchange)
		|-> !sampleTrig)
		else $error("sync1 triggered sample");

	chk_sync0_arms: assert property (@(posedge clk) disable iff (!nrst)
		(ce && dcMode && sync0Pulse) |=> armed_q)
		else $error("sync0 did not arm trigger");

	chk_shift_frozen: assert property (@(posedge clk) disable iff (!nrst)
		run_q && $past(run_q) |-> $stable(shift_q))
		else $error("shift changed while running");

	chk_buffer_hold: assert property (@(posedge clk) disable iff (!nrst)
		(ce && frameRead && !pending_q) |=> $stable(pdPosition))
		else $error("position changed without new sample");

	chk_buffer_load: assert property (@(posedge clk) disable iff (!nrst)
		(ce && frameRead && pending_q) |=>
		(pdPosition == $past(hold_q)) && pdFresh)
		else $error("sample not copied whole");

	chk_no_fresh: assert property (@(posedge clk) disable iff (!nrst)
		(ce && frameRead && !pending_q) |=> !pdFresh)
		else $error("fresh flagged without sample");

	chk_conv_busy: assert property (@(posedge clk) disable iff (!nrst)
		(ce && sampleTrig && !busy) |=> busy)
		else $error("conversion did not start");

	chk_lag_pending: assert property (@(posedge clk) disable iff (!nrst)
		(ce && done) |=> pending_q)
		else $error("completed sample not pending");
endmodule
`default_nettype wire

// ===== logic/ests_pkg.sv
package ests_pkg;
	// register byte offsets
	localparam logic [7:0]  ADDR_CTRL     = 8'h00;
	localparam logic [7:0]  ADDR_PERIOD   = 8'h04;
	localparam logic [7:0]  ADDR_SHIFT    = 8'h08;
	localparam logic [7:0]  ADDR_STATUS   = 8'h0C;
	localparam logic [7:0]  ADDR_POS      = 8'h10;
	localparam logic [7:0]  ADDR_INSHIFT  = 8'h14;
	localparam logic [7:0]  ADDR_MINCYC   = 8'h18;
	localparam logic [7:0]  ADDR_MISSED   = 8'h1C;
	// control fields
	localparam int          CTRL_MODE_LSB = 0;
	localparam int          CTRL_EN_BIT   = 8;
	localparam int          CTRL_RUN_BIT  = 9;
	localparam int          CTRL_MEAS_BIT = 10;
	// synchronisation mode codes
	localparam logic [7:0]  MODE_SYNC0    = 8'h02;
	localparam logic [7:0]  MODE_FRAME    = 8'h22;
	// reset values
	localparam logic [31:0] PERIOD_RST    = 32'h000F4240;
	localparam logic [7:0]  MODE_RST      = MODE_FRAME;
	// timing and axi response codes
	localparam int          CLK_NS        = 8;
	localparam int          CONV_US       = 80;
	localparam int          CONV_CYC      = (CONV_US * 1000) / CLK_NS;
	localparam logic [1:0]  RESP_OKAY     = 2'b00;
	localparam logic [1:0]  RESP_SLVERR   = 2'b10;
endpackage

// ===== logic/ests_sampler.sv
`timescale 1ns/1ns
`default_nettype none
// latches the counter value at a trigger and flags it done after a conversion delay
module ests_sampler
	import ests_pkg::*;
#(
	parameter int WIDTH   = 32,
	parameter int LATENCY = CONV_CYC
) (
	input  wire logic             clk,
	input  wire logic             nrst,
	input  wire logic             ce,
	input  wire logic             trig,
	input  wire logic [WIDTH-1:0] cntIn,
	output logic                  busy,
	output logic                  done,
	output logic [WIDTH-1:0]      sample
);
	initial begin
		if (LATENCY < 1 || WIDTH < 1)
			$error("bad sampler parameters");
	end

	logic [31:0] cnt_q;
	logic        busy_q;
	logic        done_q;
	logic [WIDTH-1:0] sample_q;

	always_ff @(posedge clk) begin
		if (!nrst) begin
			cnt_q    <= 32'h0;
			busy_q   <= 1'b0;
			done_q   <= 1'b0;
			sample_q <= '0;
		end else if (ce) begin
			done_q <= 1'b0;
			if (trig && !busy_q) begin
				sample_q <= cntIn;
				busy_q   <= 1'b1;
				cnt_q    <= 32'(LATENCY - 1);
			end else if (busy_q) begin
				if (cnt_q == 32'h0) begin
					busy_q <= 1'b0;
					done_q <= 1'b1;
				end else begin
					cnt_q <= cnt_q - 32'h1;
				end
			end
		end
	end

	assign busy   = busy_q;
	assign done   = done_q;
	assign sample = sample_q;
endmodule
`default_nettype wire

// ===== tb/ests_master_model.sv
`timescale 1ns/1ns
`default_nettype none
// far side: sync and frame pulses, one cycle each, launched after an edge,
// then one idle edge so back-to-back pulses never overlap
module ests_master_model (
	input  wire logic clk,
	output logic      sync0Pulse,
	output logic      sync1Pulse,
	output logic      frameExchange,
	output logic      frameRead
);
	logic [3:0] pv_q = 4'h0;

	assign {frameRead, frameExchange, sync1Pulse, sync0Pulse} = pv_q;

	// k: 0 sync0, 1 sync1, 2 exchange, 3 retrieving read
	task automatic pulse(input int k);
		pv_q <= 4'h1 << k;
		@(posedge clk);
		pv_q <= 4'h0;
		@(posedge clk);
	endtask
endmodule
`default_nettype wire

// ===== tb/encoder_sample_trigger_sync_tb.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin \
	n_errors++; $display("Error %0t: got %h exp %h", $time, a, b); end end
module encoder_sample_trigger_sync_tb;
	import ests_pkg::*;
	localparam int LAT = 20;
	// input shift that the master computes and adds to the user shift
	localparam int IN_SHIFT = 16;
	logic        clk = 1'b0;
	logic        nrst = 1'b0;
	logic        ce = 1'b1;
	logic [31:0] counterIn = 32'h0;
	logic        sync0Pulse, sync1Pulse, frameExchange, frameRead;
	logic [31:0] pdPosition;
	logic        pdFresh, sampleTrig;
	logic [7:0]  s_axi_awaddr = 8'h00;
	logic [7:0]  s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [31:0] s_axi_rdata;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic        s_axi_awvalid = 1'b0;
	logic        s_axi_wvalid = 1'b0;
	logic        s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0;
	logic        s_axi_rready = 1'b0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic        s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [33:0] expQ[$];
	int          n_errors = 0;
	int          total_checks = 0;
	int          cyc = 0;
	int          tSrc = 0;
	int          tTrig = 0;
	int          nTrig = 0;
	logic        frDly = 1'b0;
	logic [31:0] v;

	ests_trigger_sync #(.LATENCY(LAT)) ests_trigger_sync_inst (
		.clk, .nrst, .ce, .counterIn, .sync0Pulse, .sync1Pulse,
		.frameExchange, .frameRead, .pdPosition, .pdFresh, .sampleTrig,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready
	);

	ests_master_model ests_master_model_inst (
		.clk, .sync0Pulse, .sync1Pulse, .frameExchange, .frameRead
	);

	always #4 clk = ~clk;

	task automatic summarize();
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic cmpQ(input logic [33:0] r);
		logic [33:0] e;
		if (expQ.size() == 0)
			e = {2'b11, ~r[31:0]};
		else
			e = expQ.pop_front();
		`CHK(r, e)
	endtask

	// watcher: trigger timing and every read result against the notes
	always @(posedge clk) begin
		cyc <= cyc + 1;
		frDly <= frameRead;
		if (sync0Pulse || frameExchange)
			tSrc <= cyc;
		if (sampleTrig !== 1'b0) begin
			tTrig <= cyc;
			nTrig <= nTrig + 1;
		end
		if (s_axi_rvalid && s_axi_rready)
			cmpQ({s_axi_rresp, s_axi_rdata});
		if (frDly)
			cmpQ({2'b00, pdPosition} | {1'b0, pdFresh, 32'h0});
		if (cyc > 20000) begin
			n_errors++;
			summarize();
		end
	end

	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] r);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end while ((s_axi_awvalid && !s_axi_awready) ||
			(s_axi_wvalid && !s_axi_wready));
		do @(posedge clk); while (s_axi_bvalid !== 1'b1);
		`CHK(s_axi_bresp, r)
		s_axi_bready <= 1'b0;
		@(posedge clk);
	endtask

	task automatic rd(input logic [7:0] a, input logic [33:0] e);
		expQ.push_back(e);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge clk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge clk); while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		@(posedge clk);
	endtask

	// retrieving frame, expected freshness and position noted first
	task automatic frd(input logic f, input logic [31:0] p);
		expQ.push_back({1'b0, f, p});
		ests_master_model_inst.pulse(3);
		repeat (2) @(posedge clk);
	endtask

	// clock mode with a given shift, locked-shift check, then the run
	task automatic dc(input logic [31:0] sh);
		int d;
		int n0;
		logic [31:0] ish;
		d = ($signed(sh) < 0) ? 1 : sh / 8 + 1;
		ish = ($signed(sh) < 0) ? 32'h0 : sh;
		wr(ADDR_CTRL, 32'h0000_0102, RESP_OKAY);
		wr(ADDR_SHIFT, sh, RESP_OKAY);
		wr(ADDR_CTRL, 32'h0000_0702, RESP_OKAY);
		wr(ADDR_SHIFT, 32'h0000_0050, RESP_OKAY);
		rd(ADDR_SHIFT, {RESP_OKAY, sh});
		v = $urandom;
		counterIn <= v;
		n0 = nTrig;
		ests_master_model_inst.pulse(2);
		ests_master_model_inst.pulse(1);
		repeat (3) @(posedge clk);
		`CHK(nTrig, n0)
		ests_master_model_inst.pulse(0);
		repeat (d + 2) @(posedge clk);
		`CHK(tTrig - tSrc, d)
		`CHK(nTrig, n0 + 1)
		counterIn <= $urandom;
		repeat (LAT + 4) @(posedge clk);
		frd(1'b1, v);
		rd(ADDR_INSHIFT, {RESP_OKAY, ish});
		rd(ADDR_MINCYC, {RESP_OKAY, 32'((LAT + 1) * CLK_NS)});
	endtask

	initial begin
		void'($urandom(87479));
		repeat (6) @(posedge clk);
		nrst <= 1'b1;
		rd(ADDR_PERIOD, {RESP_OKAY, PERIOD_RST});
		rd(ADDR_CTRL, {RESP_OKAY, 24'h0, MODE_RST});
		rd(8'h24, {RESP_SLVERR, 32'h0});
		wr(8'h24, 32'h1, RESP_SLVERR);
		wr(ADDR_PERIOD, 32'hFFFF_FFFF, RESP_OKAY);
		rd(ADDR_PERIOD, {RESP_OKAY, 32'hFFFF_FFFF});
		// low two bytes only
		s_axi_wstrb <= 4'h3;
		wr(ADDR_PERIOD, 32'h1234_5678, RESP_OKAY);
		s_axi_wstrb <= 4'hF;
		rd(ADDR_PERIOD, {RESP_OKAY, 32'hFFFF_5678});
		ests_master_model_inst.pulse(0);
		repeat (3) @(posedge clk);
		`CHK(nTrig, 0)
		v = $urandom;
		counterIn <= v;
		ests_master_model_inst.pulse(2);
		@(posedge clk);
		counterIn <= $urandom;
		`CHK(tTrig - tSrc, 0)
		frd(1'b0, 32'h0);
		repeat (LAT + 4) @(posedge clk);
		frd(1'b1, v);
		frd(1'b0, v);
		// frozen: a frame with ce low must not count a miss
		ce <= 1'b0;
		frd(1'b0, v);
		ce <= 1'b1;
		rd(ADDR_MISSED, {RESP_OKAY, 32'h2});
		dc(($urandom % 8) * 8 + IN_SHIFT);
		dc(32'hFFFF_FFF8);
		repeat (4) @(posedge clk);
		summarize();
	end
endmodule
`default_nettype wire
